// ---- rtl/pmcr_pkg.sv ----
package pmcr_pkg;
    // register indices; byte address is four times the index
    localparam logic [1:0] CAP_IDX = 2'h0;
    localparam logic [1:0] CTL_IDX = 2'h1;
    localparam logic [1:0] DRV_IDX = 2'h2;
    // capability word, upper half
    localparam logic [4:0] WAKE_SUP_BUS = 5'h03;
    localparam logic [4:0] WAKE_SUP_AUX = 5'h1f;
    localparam logic       D2_SUP       = 1'h1;
    localparam logic       D1_SUP       = 1'h1;
    localparam logic [2:0] AUX_CURRENT  = 3'h0;
    localparam logic       DSI_NEEDED   = 1'h1;
    localparam logic       AUX_NEEDED   = 1'h0;
    localparam logic       CLK_NEEDED   = 1'h0;
    localparam logic [2:0] PM_VERSION   = 3'h2;
    // capability word, lower half: list id and next pointer
    localparam logic [7:0] CAP_ID       = 8'h01;
    localparam logic [7:0] CAP_NEXT     = 8'h00;
    // control/status word field positions
    localparam int WAKE_STAT_BIT = 15;
    localparam int SCALE_LSB     = 13;
    localparam int SEL_LSB       = 9;
    localparam int WAKE_EN_BIT   = 8;
    localparam int DYN_BIT       = 4;
    localparam int STATE_LSB     = 0;
    localparam int FIGURE_LSB    = 24;
    // reset values
    localparam logic [3:0] SEL_RST   = 4'h0;
    localparam logic [1:0] STATE_RST = 2'h0;
    // figure table, units of 0.01 W
    localparam logic [3:0] SEL_LAST_SCALED = 4'h8;
    localparam logic [1:0] SCALE_CENTI     = 2'h2;
    localparam logic [1:0] SCALE_NONE      = 2'h0;
    localparam logic [7:0] USE_D0   = 8'h3c;
    localparam logic [7:0] USE_LOW  = 8'h2a;
    localparam logic [7:0] HEAT_D0  = 8'h3a;
    localparam logic [7:0] HEAT_LOW = 8'h28;
    localparam logic [7:0] FIG_ZERO = 8'h00;
    typedef enum logic [1:0] {PMCR_D0, PMCR_D1, PMCR_D2, PMCR_D3} pmcr_state_e;
endpackage : pmcr_pkg

// ---- rtl/pmcr_reg_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface pmcr_reg_if;
    logic        wrStb;
    logic [1:0]  index;
    logic [31:0] wrData;
    logic [3:0]  wrStrb;
    logic [31:0] capWord;
    logic [31:0] ctlWord;
    logic [31:0] drvWord;
    logic [3:0]  dataSelect;
    logic [7:0]  figure;
    logic [1:0]  scale;
    modport front (output wrStb, index, wrData, wrStrb,
                   input  capWord, ctlWord, drvWord);
    modport core  (input  wrStb, index, wrData, wrStrb, figure, scale,
                   output capWord, ctlWord, drvWord, dataSelect);
    modport lut   (input dataSelect, output figure, scale);
endinterface : pmcr_reg_if
`default_nettype wire

// ---- rtl/pmcr_figure_lut.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmcr_figure_lut
    import pmcr_pkg::*;
(
    pmcr_reg_if.lut lut
);
    // hard-wired figures, no storage
    always_comb begin
        case (lut.dataSelect)
            4'h0: lut.figure = USE_D0;
            4'h1, 4'h2, 4'h3: lut.figure = USE_LOW;
            4'h4: lut.figure = HEAT_D0;
            4'h5, 4'h6, 4'h7: lut.figure = HEAT_LOW;
            default: lut.figure = FIG_ZERO;
        endcase
        if (lut.dataSelect <= SEL_LAST_SCALED) begin
            lut.scale = SCALE_CENTI;
        end else begin
            lut.scale = SCALE_NONE;
        end
    end
endmodule : pmcr_figure_lut
`default_nettype wire

// ---- rtl/pmcr_apb_front.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmcr_apb_front
    import pmcr_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    pmcr_reg_if.front              bus
);
    logic mapped;

    assign mapped = (paddr[ADDR_W-1:4] == '0) && (paddr[1:0] == 2'h0)
                    && (paddr[3:2] != 2'h3);
    assign bus.index  = paddr[3:2];
    assign bus.wrData = pwdata;
    assign bus.wrStrb = pstrb;
    assign bus.wrStb  = psel && penable && pwrite && mapped;
    // zero wait states; read data is caught in the setup cycle
    assign pready = 1'b1;

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= !mapped;
            if (!mapped || pwrite) begin
                prdata <= 32'h0000_0000;
            end else if (paddr[3:2] == CAP_IDX) begin
                prdata <= bus.capWord;
            end else if (paddr[3:2] == CTL_IDX) begin
                prdata <= bus.ctlWord;
            end else begin
                prdata <= bus.drvWord;
            end
        end
    end
endmodule : pmcr_apb_front
`default_nettype wire

// ---- rtl/pmcr_regs.sv ----
// Overview of operation
// - auxiliary-current field, capability bits 24:22, reads zero.
// - capability bit 21 reads one: driver init needed after D3 to D0.
// - capability bit 20 reads zero on bus power.
// - capability bit 19 reads zero: no clock needed for a wake event.
// - version field, capability bits 18:16, reads two.
// - wake status bit 15 sets on any wake event, enable or not; resets zero unless aux power is kept.
// - writing one to wake status clears it, the wake output and driver copy.
// - with wake enabled, the wake output follows wake status exactly.
// - wake output asserts only while enable bit 8 is set; enable resets zero.
// - scale bits 14:13 read two for selects 0 to 8, zero for 9 to 15.
// - data-select bits 12:9 choose the figure and scale; reset to zero.
// - reserved bits 7:5 and 3:2 read zero; software writes zeros.
// - bit 4 reads zero: no dynamic power monitoring.
// - power-state bits 1:0 read/write, reset zero, writing requests a state.
// - eight-bit read-only figure register, hard-wired, units of 0.01 W.
// - select 0 gives 60, selects 1 to 3 give 42.
// - select 4 gives 58, selects 5 to 7 give 40.
// - select 8 and selects 9 to 15 give zero.
// - wake-support bits 31:27 read 00011b on bus power, 11111b with aux.
// - capability bits 26 and 25 read one: D2 and D1 supported.
`timescale 1ns/1ps
`default_nettype none
module pmcr_regs
    import pmcr_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // chip side
    input  wire logic              wakeEvent,
    input  wire logic              auxPowerPin,
    output logic                   wakeOut,
    output logic                   driverWakeFlag,
    output logic      [1:0]        powerState,
    output logic                   powerStateLoad
);
    pmcr_reg_if bus ();

    logic       auxMeta;
    logic       auxPower;
    logic       wakeStatus;
    logic       wakeEnable;
    logic [3:0] dataSelect;
    logic       ctlWrite;
    logic       clearHit;
    logic       ctlHiWrite;
    logic       ctlLoWrite;
    logic       next_wakeStatus;
    logic       next_wakeEnable;

    pmcr_apb_front #(
        .ADDR_W (ADDR_W)
    ) u_front (
        .clk     (clk),
        .rst     (rst),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .bus     (bus)
    );

    pmcr_figure_lut u_lut (
        .lut (bus)
    );

    // aux-power strap comes from a pin; synchroniser is not reset
    always_ff @(posedge clk) begin
        auxMeta  <= auxPowerPin;
        auxPower <= auxMeta;
    end

    // byte-lane decode of a control-word write, shared by every field load
    function automatic logic laneWrite(input logic hit, input logic [3:0] strb,
                                       input int lane);
        return hit && strb[lane];
    endfunction : laneWrite

    assign ctlWrite   = bus.wrStb && (bus.index == CTL_IDX);
    assign ctlHiWrite = laneWrite(ctlWrite, bus.wrStrb, 1);
    assign ctlLoWrite = laneWrite(ctlWrite, bus.wrStrb, 0);
    assign clearHit   = ctlHiWrite && bus.wrData[WAKE_STAT_BIT];

    // a wake event in the clearing cycle wins over the clear
    always_comb begin
        next_wakeStatus = wakeStatus;
        if (clearHit) begin
            next_wakeStatus = 1'b0;
        end
        if (wakeEvent) begin
            next_wakeStatus = 1'b1;
        end
        next_wakeEnable = wakeEnable;
        if (ctlHiWrite) begin
            next_wakeEnable = bus.wrData[WAKE_EN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            // status kept only while aux power holds the wake logic
            if (auxPower) begin
                wakeStatus <= wakeStatus;
            end else begin
                wakeStatus <= 1'b0;
            end
        end else begin
            wakeStatus <= next_wakeStatus;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wakeEnable <= 1'b0;
            wakeOut    <= 1'b0;
        end else begin
            wakeEnable <= next_wakeEnable;
            // registered from next values so it equals the and of the bits
            wakeOut    <= next_wakeStatus && next_wakeEnable;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dataSelect <= SEL_RST;
        end else if (ctlHiWrite) begin
            dataSelect <= bus.wrData[SEL_LSB +: 4];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            powerState     <= STATE_RST;
            powerStateLoad <= 1'b0;
        end else begin
            powerStateLoad <= ctlLoWrite;
            if (ctlLoWrite) begin
                powerState <= bus.wrData[STATE_LSB +: 2];
            end
        end
    end

    // driver copy of the wake status, for the driver register
    assign driverWakeFlag = wakeStatus;

    assign bus.dataSelect = dataSelect;

    always_comb begin
        bus.capWord = 32'h0000_0000;
        bus.capWord[31:27] = auxPower ? WAKE_SUP_AUX : WAKE_SUP_BUS;
        bus.capWord[26]    = D2_SUP;
        bus.capWord[25]    = D1_SUP;
        bus.capWord[24:22] = AUX_CURRENT;
        bus.capWord[21]    = DSI_NEEDED;
        bus.capWord[20]    = AUX_NEEDED;
        bus.capWord[19]    = CLK_NEEDED;
        bus.capWord[18:16] = PM_VERSION;
        bus.capWord[15:8]  = CAP_NEXT;
        bus.capWord[7:0]   = CAP_ID;
    end

    // unused bits, reserved bits and the dynamic bit stay zero
    always_comb begin
        bus.ctlWord = 32'h0000_0000;
        bus.ctlWord[WAKE_STAT_BIT]      = wakeStatus;
        bus.ctlWord[SCALE_LSB +: 2]     = bus.scale;
        bus.ctlWord[SEL_LSB +: 4]       = dataSelect;
        bus.ctlWord[WAKE_EN_BIT]        = wakeEnable;
        bus.ctlWord[STATE_LSB +: 2]     = powerState;
        bus.ctlWord[FIGURE_LSB +: 8]    = bus.figure;
    end

    always_comb begin
        bus.drvWord    = 32'h0000_0000;
        bus.drvWord[0] = wakeStatus;
        bus.drvWord[1] = wakeOut;
    end

    // expected table for the checks below
    function automatic logic [7:0] expFigure(input logic [3:0] sel);
        logic [7:0] f;
        f = FIG_ZERO;
        if (sel == 4'h0) begin
            f = USE_D0;
        end else if (sel <= 4'h3) begin
            f = USE_LOW;
        end else if (sel == 4'h4) begin
            f = HEAT_D0;
        end else if (sel <= 4'h7) begin
            f = HEAT_LOW;
        end
        return f;
    endfunction : expFigure

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_ctl_write_hi;
        ctlWrite && bus.wrStrb[1];
    endsequence

    sequence s_clear_alone;
        clearHit && !wakeEvent;
    endsequence

    sequence s_state_write;
        ctlWrite && bus.wrStrb[0];
    endsequence

    a_wake_pin_follow: assert property (
        wakeOut == (wakeStatus && wakeEnable)
    ) else $error("wake output does not track status and enable");

    a_event_sets: assert property (
        wakeEvent |=> wakeStatus && driverWakeFlag
    ) else $error("wake event did not set the status");

    a_clear_drops: assert property (
        s_clear_alone |=> !wakeStatus && !wakeOut && !driverWakeFlag
    ) else $error("write one did not clear wake status");

    a_status_holds: assert property (
        !wakeEvent && !clearHit |=> wakeStatus == $past(wakeStatus)
    ) else $error("wake status changed without cause");

    a_enable_gates: assert property (
        !wakeEnable ##1 !wakeEnable |-> !wakeOut
    ) else $error("wake output high while disabled");

    a_select_load: assert property (
        s_ctl_write_hi |=> dataSelect == $past(bus.wrData[12:9])
    ) else $error("data select not loaded");

    a_scale_code: assert property (
        bus.ctlWord[14:13] == ((dataSelect <= 4'h8) ? 2'h2 : 2'h0)
    ) else $error("scale code wrong for select");

    a_figure_table: assert property (
        bus.ctlWord[31:24] == expFigure(dataSelect)
    ) else $error("figure does not match select");

    a_reserved_zero: assert property (
        bus.ctlWord[7:2] == 6'h00
    ) else $error("reserved or dynamic bit not zero");

    a_state_load: assert property (
        s_state_write |=> powerStateLoad
            && powerState == $past(bus.wrData[1:0])
    ) else $error("power state write not applied");

    a_cap_fixed: assert property (
        bus.capWord[26:16] == 11'h622
    ) else $error("fixed capability bits wrong");

    a_wake_support: assert property (
        bus.capWord[31:27] == ($past(auxPowerPin, 2) ? 5'h1f : 5'h03)
    ) else $error("wake support field wrong for supply");

    a_reset_clear: assert property (
        $fell(rst) && !auxPower |-> !wakeStatus && !wakeEnable
            && powerState == 2'h0 && dataSelect == 4'h0
    ) else $error("reset left control state set");

    sequence s_event_and_clear;
        wakeEvent && clearHit;
    endsequence

    sequence s_zero_write;
        ctlHiWrite && !bus.wrData[WAKE_STAT_BIT] && wakeStatus;
    endsequence

    sequence s_unmapped_setup;
        psel && !penable && paddr[3:2] == 2'h3;
    endsequence

    a_set_wins: assert property (
        s_event_and_clear |=> wakeStatus && driverWakeFlag
    ) else $error("clear beat a wake event in the same cycle");

    a_zero_keeps: assert property (
        s_zero_write |=> wakeStatus
    ) else $error("writing zero cleared wake status");

    a_enable_load: assert property (
        ctlHiWrite |=> wakeEnable == $past(bus.wrData[WAKE_EN_BIT])
    ) else $error("wake enable not loaded");

    a_enable_holds: assert property (
        !ctlHiWrite |=> wakeEnable == $past(wakeEnable)
    ) else $error("wake enable changed without a write");

    a_select_holds: assert property (
        !ctlHiWrite |=> dataSelect == $past(dataSelect)
    ) else $error("data select changed without a write");

    a_state_holds: assert property (
        !ctlLoWrite |=> powerState == $past(powerState) && !powerStateLoad
    ) else $error("power state changed without a write");

    a_load_pulse: assert property (
        powerStateLoad |-> $past(ctlLoWrite)
    ) else $error("state load pulse without a write");

    a_word_fields: assert property (
        bus.ctlWord[15] == wakeStatus && bus.ctlWord[8] == wakeEnable
            && bus.ctlWord[12:9] == dataSelect && bus.ctlWord[1:0] == powerState
    ) else $error("control word fields do not show the state");

    a_driver_copy: assert property (
        bus.drvWord == {30'h0, wakeOut, wakeStatus} && driverWakeFlag == wakeStatus
    ) else $error("driver copy does not show wake status");

    a_wake_on_event: assert property (
        wakeEvent && wakeEnable && !ctlHiWrite |=> wakeOut
    ) else $error("enabled wake event did not raise the wake output");

    a_figure_high_zero: assert property (
        dataSelect >= 4'h8 |-> bus.figure == 8'h00
    ) else $error("figure not zero for upper selects");

    a_cap_list: assert property (
        bus.capWord[15:0] == 16'h0001
    ) else $error("capability list entry wrong");

    a_unmapped_err: assert property (
        s_unmapped_setup |=> pslverr && prdata == 32'h0000_0000
    ) else $error("unmapped access not refused");

endmodule : pmcr_regs
`default_nettype wire

// ---- bench/pmcr_wake_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmcr_wake_model (
    // command from the bench
    input  wire logic       clk,
    input  wire logic       fire,
    input  wire logic [2:0] gap,
    // wake line into the block
    output logic            wakeEvent
);
    logic [3:0] cnt = 4'h0;
    // one pulse, gap cycles after fire; fires while counting are dropped
    always_ff @(posedge clk) begin
        if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (fire) begin
            cnt <= {1'b0, gap} + 4'h1;
        end
    end
    assign wakeEvent = (cnt == 4'h1);
endmodule : pmcr_wake_model
`default_nettype wire

// ---- bench/pmcr_regs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmcr_regs_tb_top;
    logic        clk, rst, psel, penable, pwrite, auxPowerPin, fire;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [2:0]  gap;
    logic        pready, pslverr, wakeEvent, wakeOut, driverWakeFlag, powerStateLoad;
    logic [1:0]  powerState;
    logic [32:0] expq[$];
    int          fails, checked, cyc;

    pmcr_regs u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wakeEvent(wakeEvent), .auxPowerPin(auxPowerPin),
        .wakeOut(wakeOut), .driverWakeFlag(driverWakeFlag), .powerState(powerState),
        .powerStateLoad(powerStateLoad));
    pmcr_wake_model u_wake (.clk(clk), .fire(fire), .gap(gap), .wakeEvent(wakeEvent));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
        checked++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic pin(input string n, input logic e, input logic s);
        chk(n, {32'h0, e}, {32'h0, s});
    endtask : pin

    task automatic results();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results

    function automatic logic [7:0] fig(input logic [3:0] s);
        case (s)
            4'h0: fig = 8'h3c;
            4'h1, 4'h2, 4'h3: fig = 8'h2a;
            4'h4: fig = 8'h3a;
            4'h5, 4'h6, 4'h7: fig = 8'h28;
            default: fig = 8'h00;
        endcase
    endfunction : fig

    // expected {pslverr, prdata} of the control word
    function automatic logic [32:0] ctl(input logic w, input logic [3:0] s, input logic e,
                                        input logic [1:0] st);
        ctl = {1'b0, fig(s), 8'h00, w, (s <= 4'h8) ? 2'h2 : 2'h0, s, e, 6'h00, st};
    endfunction : ctl

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [32:0] e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        if (!wr) expq.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
        if (wr && a == 8'h04 && s[0]) begin
            pin("load", 1'b1, powerStateLoad);
            chk("state", {31'h0, d[1:0]}, {31'h0, powerState});
        end
        @(posedge clk);
    endtask : apb

    task automatic wake(input logic en);
        int n;
        fire <= 1'b1;
        gap <= 3'($urandom);
        @(posedge clk);
        fire <= 1'b0;
        n = 0;
        while (driverWakeFlag !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        #1;
        pin("flag", 1'b1, driverWakeFlag);
        pin("wake", en, wakeOut);
        @(posedge clk);
    endtask : wake

    // reset length in edges; the bench waits out the strap synchroniser before calling a mid-run reset
    task automatic rstp(input int n);
        rst <= 1'b1;
        repeat (n) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
    endtask : rstp

    always @(posedge clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            if (expq.size() == 0) chk("readq", 33'h0, 33'h1);
            else chk("read", expq.pop_front(), {pslverr, prdata});
        end
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            results();
        end
    end

    initial begin
        {rst, psel, penable, pwrite, auxPowerPin, fire} = 6'h20;
        {paddr, pwdata, pstrb, gap} = '0;
        fails = 0;
        checked = 0;
        cyc = 0;
        void'($urandom(1));
        rstp(2);
        pin("wake", 1'b0, wakeOut);
        chk("state", 33'h0, {31'h0, powerState});
        @(posedge clk);
        apb(1'b0, 8'h00, 32'h0, 4'h0, 33'h0_1e220001);
        apb(1'b0, 8'h04, 32'h0, 4'h0, ctl(1'b0, 4'h0, 1'b0, 2'h0));
        apb(1'b0, 8'h08, 32'h0, 4'h0, 33'h0);
        // read-only scale and bit 4 written with ones; every select and state
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, 8'h04, {16'($urandom), 16'h6010 | 16'(i << 9) | 16'(i & 3)}, 4'h3,
                33'h0);
            apb(1'b0, 8'h04, 32'h0, 4'h0, ctl(1'b0, 4'(i), 1'b0, 2'(i)));
        end
        wake(1'b0);
        apb(1'b0, 8'h04, 32'h0, 4'h0, ctl(1'b1, 4'hf, 1'b0, 2'h3));
        apb(1'b0, 8'h08, 32'h0, 4'h0, 33'h1);
        apb(1'b1, 8'h04, 32'h0000_1f00, 4'h2, 33'h0);
        pin("wake", 1'b1, wakeOut);
        apb(1'b0, 8'h08, 32'h0, 4'h0, 33'h3);
        apb(1'b1, 8'h04, 32'h0000_9f00, 4'h2, 33'h0);
        pin("flag", 1'b0, driverWakeFlag);
        pin("wake", 1'b0, wakeOut);
        apb(1'b0, 8'h04, 32'h0, 4'h0, ctl(1'b0, 4'hf, 1'b1, 2'h3));
        // event lands on the access edge of a clear: the set must win
        fire <= 1'b1;
        gap <= 3'h1;
        @(posedge clk);
        fire <= 1'b0;
        apb(1'b1, 8'h04, 32'h0000_9f00, 4'h2, 33'h0);
        pin("flag", 1'b1, driverWakeFlag);
        apb(1'b1, 8'h04, 32'h0000_9f00, 4'h2, 33'h0);
        pin("flag", 1'b0, driverWakeFlag);
        wake(1'b1);
        apb(1'b1, 8'h04, 32'h0000_1e00, 4'h2, 33'h0);
        pin("wake", 1'b0, wakeOut);
        pin("flag", 1'b1, driverWakeFlag);
        // unmapped place refused, read-only words ignore writes
        apb(1'b0, 8'h0c, 32'h0, 4'h0, {1'b1, 32'h0});
        apb(1'b1, 8'h00, 32'hffff_ffff, 4'hf, 33'h0);
        apb(1'b1, 8'h0c, 32'hffff_ffff, 4'hf, 33'h0);
        apb(1'b0, 8'h04, 32'h0, 4'h0, ctl(1'b1, 4'hf, 1'b0, 2'h3));
        apb(1'b0, 8'h00, 32'h0, 4'h0, 33'h0_1e220001);
        auxPowerPin <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, 8'h00, 32'h0, 4'h0, 33'h0_fe220001);
        // status survives a reset only while aux power is kept
        rstp(3);
        pin("flag", 1'b1, driverWakeFlag);
        chk("state", 33'h0, {31'h0, powerState});
        @(posedge clk);
        apb(1'b0, 8'h04, 32'h0, 4'h0, ctl(1'b1, 4'h0, 1'b0, 2'h0));
        auxPowerPin <= 1'b0;
        repeat (3) @(posedge clk);
        rstp(3);
        pin("flag", 1'b0, driverWakeFlag);
        results();
    end
endmodule : pmcr_regs_tb_top
`default_nettype wire
